// ### hw/rsct_map.vh
// Constants for the serial trim port: command decode, trim field layout, timebase.
// Assumes inclusion by bare name from the design files.
`ifndef RSCT_MAP_VH
`define RSCT_MAP_VH

// =====================================================================
// Addressing of the first byte
// Device code value is arbitrary
`define RSCT_DEV_CODE 4'h6
`define RSCT_CMD_TRIM 3'h3

// =====================================================================
// Trim register layout
`define RSCT_TRIM_RESET 8'h00
`define RSCT_TRIM_RES_BIT 0
`define RSCT_TRIM_STEP_MSB 7
`define RSCT_TRIM_STEP_LSB 1

// =====================================================================
// Divider chain
`define RSCT_TICKS_PER_SEC 17'h08000
`define RSCT_HALF_SEC 17'h04000
`define RSCT_LAST_SEC_COARSE 6'h13
`define RSCT_LAST_SEC_FINE 6'h3b

// =====================================================================
// Write buffer
`define RSCT_FIFO_WIDTH 8
`define RSCT_FIFO_DEPTH 8
`define RSCT_FIFO_AW 3

`endif

// ### hw/rsct_fifo.v
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps

module rsct_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clock,
  input wire srst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  wire [DEPTH-1:0] wr_sel;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // One-hot entry select keeps the per-entry test free of genvar slicing
  assign wr_sel = {{(DEPTH-1){1'b0}}, push} << wr_ptr;

  // =====================================================================
  // Storage
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      always @(posedge clock) begin
        if (srst) begin
          mem[i] <= {WIDTH{1'b0}};
        end else if (wr_sel[i]) begin
          mem[i] <= in_data;
        end
      end
    end
  endgenerate

  // =====================================================================
  // Pointers
  always @(posedge clock) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // rsct_fifo

// ### hw/rsct_top.v
// Two-wire target port of a real-time clock with its clock trim register and
// the divider chain that the trim acts on.
// Assumes an open-drain SDA resolved outside, SCL and SDA asynchronous to clock,
// and a one-cycle pulse on tick_32k for every 32.768 kHz oscillator period.
`timescale 1ns/1ps
`include "rsct_map.vh"

module rsct_top (
  // Clock and reset
  input wire clock,
  input wire srst,
  // Two-wire bus
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  // Timebase
  input wire tick_32k,
  output reg clk32k_out,
  output reg pulse_1hz,
  // Status
  output reg [7:0] trim_value,
  output reg busy
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK_A = 3'h2;
  localparam [2:0] ST_WR = 3'h3;
  localparam [2:0] ST_ACK_W = 3'h4;
  localparam [2:0] ST_RD = 3'h5;
  localparam [2:0] ST_ACK_R = 3'h6;

  // =====================================================================
  // Pin synchronisers
  reg scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  reg scl_f, sda_f, scl_p, sda_p;
  wire scl_rise, scl_fall, start_det, stop_det;

  always @(posedge clock) begin
    if (srst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      // A level counts only once two stages agree, which rejects single glitches
      if (scl_s2 == scl_s3) begin
        scl_f <= scl_s3;
      end
      if (sda_s2 == sda_s3) begin
        sda_f <= sda_s3;
      end
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign start_det = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_det = scl_f & scl_p & ~sda_p & sda_f;

  // =====================================================================
  // Write buffer between the serial port and the trim register
  wire fifo_in_ready, fifo_out_valid, fifo_out_ready;
  wire [7:0] fifo_out_data;
  reg fifo_push;
  reg [7:0] fifo_push_data;

  rsct_fifo #(
    .WIDTH(`RSCT_FIFO_WIDTH),
    .DEPTH(`RSCT_FIFO_DEPTH),
    .AW(`RSCT_FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // =====================================================================
  // Serial engine
  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] rx_shift;
  reg [7:0] tx_shift;
  reg rw_bit;
  reg drive_low;
  reg master_ack;
  reg byte_done;

  // Open drain: the pad only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_low;

  always @(posedge clock) begin
    if (srst) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      rw_bit <= 1'b0;
      drive_low <= 1'b0;
      master_ack <= 1'b0;
      byte_done <= 1'b0;
      fifo_push <= 1'b0;
      fifo_push_data <= 8'h00;
      busy <= 1'b0;
    end else begin
      fifo_push <= 1'b0;
      busy <= (state != ST_IDLE);
      if (stop_det) begin
        // Stop ends any access and returns to standby
        state <= ST_IDLE;
        drive_low <= 1'b0;
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
      end else if (start_det) begin
        // A start mid-byte aborts the old access and begins a new one
        state <= ST_ADDR;
        drive_low <= 1'b0;
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              rx_shift <= {rx_shift[6:0], sda_f};
              bit_cnt <= bit_cnt + 3'h1;
              // Bytes count on rises: the fall right after a start carries no bit
              byte_done <= (bit_cnt == 3'h7);
            end else if (scl_fall && byte_done) begin
              byte_done <= 1'b0;
              if (state == ST_ADDR) begin
                if (rx_shift[7:4] == `RSCT_DEV_CODE && rx_shift[3:1] == `RSCT_CMD_TRIM) begin
                  rw_bit <= rx_shift[0];
                  drive_low <= 1'b1;
                  state <= ST_ACK_A;
                end else begin
                  // Foreign code or command: stay off the bus
                  state <= ST_IDLE;
                end
              end else if (fifo_in_ready) begin
                fifo_push <= 1'b1;
                fifo_push_data <= rx_shift;
                drive_low <= 1'b1;
                state <= ST_ACK_W;
              end else begin
                // Buffer full: withholding the ack tells the master to back off
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (rw_bit) begin
                // First data bit must be on the line before the next rise
                tx_shift <= trim_value;
                drive_low <= ~trim_value[7];
                state <= ST_RD;
              end else begin
                drive_low <= 1'b0;
                state <= ST_WR;
              end
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              drive_low <= 1'b0;
              state <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt == 3'h7) begin
                // Release so the master can answer on the ninth clock
                drive_low <= 1'b0;
                state <= ST_ACK_R;
              end else begin
                bit_cnt <= bit_cnt + 3'h1;
                tx_shift <= {tx_shift[6:0], 1'b0};
                drive_low <= ~tx_shift[6];
              end
            end
          end
          ST_ACK_R: begin
            if (scl_rise) begin
              master_ack <= ~sda_f;
            end else if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (master_ack) begin
                tx_shift <= trim_value;
                drive_low <= ~trim_value[7];
                state <= ST_RD;
              end else begin
                // No ack ends reading; the master follows with a stop
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            drive_low <= 1'b0;
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // =====================================================================
  // Divider chain with trim
  reg [16:0] tick_cnt;
  reg [5:0] sec_cnt;
  wire [6:0] step;
  wire [5:0] last_sec;
  wire trim_second;
  wire [16:0] sec_len;

  // Undo the bit reversal of the stored step field
  genvar k;
  generate
    for (k = 0; k < 7; k = k + 1) begin : g_rev
      assign step[k] = trim_value[`RSCT_TRIM_STEP_MSB - k];
    end
  endgenerate

  // Window of 20 or 60 seconds by the resolution bit
  assign last_sec = trim_value[`RSCT_TRIM_RES_BIT] ? `RSCT_LAST_SEC_FINE : `RSCT_LAST_SEC_COARSE;
  assign trim_second = (sec_cnt >= last_sec);
  // Two oscillator periods per step in the one altered second gives the
  // 3.052 or 1.017 ppm unit; a positive step shortens it
  assign sec_len = `RSCT_TICKS_PER_SEC - {{9{step[6]}}, step, 1'b0};

  // Trim updates wait outside the altered second so one period never mixes settings
  assign fifo_out_ready = ~trim_second;

  always @(posedge clock) begin
    if (srst) begin
      trim_value <= `RSCT_TRIM_RESET;
      tick_cnt <= 17'h00000;
      sec_cnt <= 6'h00;
      pulse_1hz <= 1'b0;
      clk32k_out <= 1'b0;
    end else begin
      // The oscillator output passes untouched by any trim value
      clk32k_out <= tick_32k;
      if (fifo_out_valid && fifo_out_ready) begin
        trim_value <= fifo_out_data;
      end
      if (tick_32k) begin
        if (tick_cnt + 17'h00001 >= (trim_second ? sec_len : `RSCT_TICKS_PER_SEC)) begin
          tick_cnt <= 17'h00000;
          sec_cnt <= trim_second ? 6'h00 : sec_cnt + 6'h01;
        end else begin
          tick_cnt <= tick_cnt + 17'h00001;
        end
      end
      pulse_1hz <= (tick_cnt < `RSCT_HALF_SEC);
    end
  end

endmodule // rsct_top

// ### dv/rsct_properties.sv
// Checker of the trim port pins, bound into the top module.
// Assumes sda_in is the resolved open-drain bus level.
`timescale 1ns/1ps

module rsct_properties (
  // Clock and reset
  input wire clock,
  input wire srst,
  // Pins and status
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire tick_32k,
  input wire clk32k_out,
  input wire pulse_1hz,
  input wire [7:0] trim_value,
  input wire busy
);
  // ======
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  AST_OPEN_DRAIN:
    assert property (!sda_out) else $error("sda_out high");
  AST_RESET_STATE:
    assert property ($fell(srst) |-> (trim_value == 8'h00 && sda_oe_n && !busy && !pulse_1hz)
      ##1 pulse_1hz) else $error("bad state after reset");
  AST_TICK_THROUGH:
    assert property (tick_32k |=> clk32k_out) else $error("32k output lost a tick");
  AST_IDLE_RELEASED:
    assert property (!busy |-> sda_oe_n) else $error("SDA pulled while idle");
  AST_START_SEEN:
    assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:10] busy)
      else $error("start not taken");
  AST_STOP_SEEN:
    assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:10] !busy)
      else $error("stop not taken");
  AST_DRIVE_SCL_LOW:
    assert property ($changed(sda_oe_n) |-> !scl_in) else $error("SDA moved, SCL high");
  AST_ACK_HOLD:
    assert property (!sda_oe_n && scl_in |=> !sda_oe_n) else $error("SDA let go, SCL high");
endmodule // rsct_properties

bind rsct_top rsct_properties i_rsct_properties (
  .clock(clock), .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .tick_32k(tick_32k), .clk32k_out(clk32k_out),
  .pulse_1hz(pulse_1hz), .trim_value(trim_value), .busy(busy)
);

// ### dv/rsct_host.sv
// Behavioural two-wire bus master for the trim port.
// Assumes the bench resolves SDA with a pull-up from sda_rel and the device.
`timescale 1ns/1ps

module rsct_host (
  // Pacing clock
  input wire clock,
  // Bus lines
  output reg scl,
  output reg sda_rel,
  input wire sda
);
  // ======
  // Bus cycles: 12 low plus 13 high clocks make the 125 ns bit period
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic start_cond;
    sda_rel = 1'b1;
    hold(12);
    scl = 1'b1;
    hold(12);
    sda_rel = 1'b0;
    hold(12);
    scl = 1'b0;
  endtask
  task automatic xfer_bit(input logic b, output logic seen);
    hold(1);
    sda_rel = b;
    hold(11);
    scl = 1'b1;
    hold(12);
    seen = sda;
    hold(1);
    scl = 1'b0;
  endtask
  // Release for a read byte by passing all ones
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack);
    int i;
    for (i = 7; i >= 0; i--) xfer_bit(tx[i], rx[i]);
    xfer_bit(ack_in, ack);
  endtask
  task automatic stop_cond;
    hold(1);
    sda_rel = 1'b0;
    hold(11);
    scl = 1'b1;
    hold(12);
    sda_rel = 1'b1;
    hold(12);
  endtask
  task automatic recover;
    logic s;
    int i;
    start_cond;
    for (i = 0; i < 63; i++) xfer_bit(1'b1, s);
    stop_cond;
  endtask
endmodule // rsct_host

// ### dv/tb_top.sv
// Self-checking bench: bus accesses, write buffer and divider of the trim port.
// Assumes the design sources and the host model are compiled first.
`timescale 1ns/1ps
`include "rsct_map.vh"

module tb_top;
  // ======
  // Signals
  localparam logic [7:0] ADDR_WR = {`RSCT_DEV_CODE, `RSCT_CMD_TRIM, 1'b0};
  localparam logic [7:0] ADDR_RD = {`RSCT_DEV_CODE, `RSCT_CMD_TRIM, 1'b1};
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic tick_32k = 1'b0;
  wire scl, sda_rel, sda_out, sda_oe_n, clk32k_out, pulse_1hz, busy;
  wire [7:0] trim_value;
  wire sda = sda_rel & (sda_oe_n | sda_out);
  int err_count = 0;
  int checks_done = 0;

  always #2.5 clock = ~clock;
  rsct_host i_rsct_host (.clock(clock), .scl(scl), .sda_rel(sda_rel), .sda(sda));
  rsct_top i_rsct_top (
    .clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .tick_32k(tick_32k), .clk32k_out(clk32k_out),
    .pulse_1hz(pulse_1hz), .trim_value(trim_value), .busy(busy)
  );

  // ======
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Step count lands bit-reversed in 7:1, resolution in bit 0
  function automatic logic [7:0] trim_code(input int code, input logic fine);
    logic [7:0] v;
    int i;
    for (i = 0; i < 7; i++) v[7 - i] = code[i];
    v[0] = fine;
    return v;
  endfunction
  task automatic begin_acc(input logic [7:0] addr, input logic exp_ack);
    logic [7:0] rx;
    logic ack;
    i_rsct_host.start_cond;
    i_rsct_host.xfer_byte(addr, 1'b1, rx, ack);
    chk(ack, exp_ack);
  endtask
  task automatic write_trim(input logic [7:0] d);
    logic [7:0] rx;
    logic ack;
    begin_acc(ADDR_WR, 1'b0);
    i_rsct_host.xfer_byte(d, 1'b1, rx, ack);
    chk(ack, 1'b0);
    i_rsct_host.stop_cond;
    chk(trim_value, d);
  endtask
  task automatic read_trim(input logic [7:0] exp);
    logic [7:0] rx;
    logic ack;
    begin_acc(ADDR_RD, 1'b0);
    i_rsct_host.xfer_byte(8'hff, 1'b0, rx, ack);
    chk(rx, exp);
    i_rsct_host.xfer_byte(8'hff, 1'b1, rx, ack);
    chk(rx, exp);
    i_rsct_host.stop_cond;
    chk(busy, 1'b0);
  endtask
  task automatic count_level(input logic lvl, output int n);
    n = 0;
    while (pulse_1hz === lvl && n < 40000) begin
      n++;
      @(negedge clock);
    end
    if (n == 40000) begin
      err_count++;
      close_out;
    end
  endtask

  // ======
  // Scenarios
  task automatic reset_state;
    chk({trim_value, sda_oe_n, busy}, {8'h00, 2'b10});
    chk({clk32k_out, pulse_1hz, sda_out}, 3'b010);
  endtask
  task automatic trim_codes;
    int codes[5] = '{128 - 22, 26 + 1, 128 - 64, 62, 0};
    logic fine[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    int i;
    for (i = 0; i < 5; i++) begin
      write_trim(trim_code(codes[i], fine[i]));
      read_trim(trim_code(codes[i], fine[i]));
    end
  endtask
  task automatic refuse_and_abort;
    logic [7:0] rx;
    logic ack;
    int i;
    begin_acc({~`RSCT_DEV_CODE, `RSCT_CMD_TRIM, 1'b0}, 1'b1);
    i_rsct_host.stop_cond;
    begin_acc({`RSCT_DEV_CODE, ~`RSCT_CMD_TRIM, 1'b0}, 1'b1);
    i_rsct_host.stop_cond;
    begin_acc(ADDR_WR, 1'b0);
    i_rsct_host.xfer_byte(8'h3c, 1'b1, rx, ack);
    i_rsct_host.xfer_byte(8'hd8, 1'b1, rx, ack);
    chk(ack, 1'b0);
    for (i = 0; i < 4; i++) i_rsct_host.xfer_bit(1'b0, ack);
    i_rsct_host.stop_cond;
    chk(trim_value, 8'hd8);
  endtask
  task automatic recover_bus;
    logic s;
    begin_acc(ADDR_RD, 1'b0);
    i_rsct_host.xfer_bit(1'b1, s);
    i_rsct_host.xfer_bit(1'b1, s);
    i_rsct_host.hold(8);
    chk(sda, 1'b0);
    i_rsct_host.recover;
    chk({sda_oe_n, busy}, 2'b10);
    write_trim(8'h00);
  endtask
  // Eight bytes in one access pass the write buffer in order; the last one stays
  task automatic write_burst;
    logic [7:0] rx;
    logic [7:0] d;
    logic ack;
    int i;
    begin_acc(ADDR_WR, 1'b0);
    for (i = 0; i < 8; i++) begin
      d = (i == 7) ? 8'h00 : 8'ha0 + i[7:0];
      i_rsct_host.xfer_byte(d, 1'b1, rx, ack);
      chk(ack, 1'b0);
      chk(trim_value, d);
    end
    i_rsct_host.stop_cond;
    chk(trim_value, 8'h00);
    chk(busy, 1'b0);
  endtask
  // A tick every clock: halves of a plain second are 16384 ticks each
  task automatic check_divider;
    int n;
    tick_32k = 1'b1;
    count_level(1'b1, n);
    count_level(1'b0, n);
    chk(n, 16384);
    count_level(1'b1, n);
    chk(n, 16384);
    chk(clk32k_out, 1'b1);
  endtask

  initial begin
    repeat (12) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    reset_state;
    trim_codes;
    refuse_and_abort;
    recover_bus;
    write_burst;
    check_divider;
    close_out;
  end
endmodule // tb_top
